// ---- rtl/tcg_pkg.sv ----
// constants and types for the torque compensation and range guard
package tcg_pkg;
  localparam int TRQ_W = 12;
  localparam int POS_W = 32;
  localparam int SPAN_W = 11;
  localparam logic signed [11:0] OFFSET_MIN = -12'sd100;
  localparam logic signed [11:0] OFFSET_MAX = 12'sd100;
  localparam logic [9:0] CEIL_MAX = 10'h1F4;
  localparam logic [10:0] SPAN_MAX = 11'h3E8;
  localparam logic [1:0] SEL_BOTH_FIRST = 2'h1;
  localparam logic [1:0] SEL_BY_DIR = 2'h2;
  localparam logic [1:0] SEL_BY_INPUT = 2'h3;
  localparam logic [11:0] TRQ_ZERO = 12'h000;
  localparam logic [31:0] POS_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNTS_PER_TENTH_REV = 32'h0000_0CCD;
  typedef enum logic [1:0] {TCG_POSITION, TCG_VELOCITY, TCG_TORQUE, TCG_FULL_CLOSED} tcg_mode_e;
endpackage

// ---- rtl/tcg_torque_guard.sv ----
// torque compensation, limit selection and working range guard
// Operation
// - friction compensation runs only in servo-on with normal command path
// - bias offset always added except in torque control mode
// - forward command adds forward friction offset in position or full-closed mode
// - reverse command adds reverse friction offset in position or full-closed mode
// - after servo-on, compensation held until the first position command
// - on command start, bias compensation reloaded from its setting
// - on command start, friction compensation reloaded by command direction
// - two torque ceilings, each 0 to 500 percent
// - mode 1 applies first ceiling to both directions
// - mode 2 applies first positive, second negative
// - mode 3 picks first or second ceiling by the select input
// - limit switching active only in servo-on with normal command path
// - alarm when position leaves command range widened by working span
// - range guard evaluated only in servo-on with normal command path
// - working span 0 to 1000 tenths of a revolution
// - command range cleared at reset, deviation clear, comm trial start and end
// - range guard disabled during panel trial and frequency analysis
`timescale 1ns/1ns
module tcg_torque_guard #(
  parameter int TRQ_W = tcg_pkg::TRQ_W,
  parameter int POS_W = tcg_pkg::POS_W,
  parameter logic [31:0] COUNTS_PER_TENTH = tcg_pkg::COUNTS_PER_TENTH_REV
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // state and mode
  input wire logic servo_on_i,
  input wire logic path_normal_i,
  input wire logic [1:0] ctrl_mode_i,
  input wire logic dev_clear_i,
  input wire logic comm_trial_i,
  input wire logic panel_trial_i,
  input wire logic freq_analysis_i,
  input wire logic torque_limit_select_input,
  // settings
  input wire logic signed [TRQ_W-1:0] bias_torque_offset,
  input wire logic signed [TRQ_W-1:0] fwd_friction_offset,
  input wire logic signed [TRQ_W-1:0] rev_friction_offset,
  input wire logic [9:0] first_torque_ceiling,
  input wire logic [9:0] second_torque_ceiling,
  input wire logic [1:0] ceiling_select_mode,
  input wire logic [tcg_pkg::SPAN_W-1:0] working_range_span,
  // command and feedback
  input wire logic cmd_active_i,
  input wire logic cmd_fwd_i,
  input wire logic signed [POS_W-1:0] cmd_pos_delta_i,
  input wire logic signed [POS_W-1:0] motor_pos_i,
  input wire logic signed [TRQ_W-1:0] torque_cmd_i,
  // outputs
  output logic signed [TRQ_W-1:0] torque_out_o,
  output logic [9:0] pos_ceiling_o,
  output logic [9:0] neg_ceiling_o,
  output logic range_alarm_o
);
  logic sync1_ff, sync2_ff;
  logic signed [TRQ_W-1:0] bias_ff, nxt_bias;
  logic signed [TRQ_W-1:0] fric_ff, nxt_fric;
  logic cmd_prev_ff, nxt_cmd_prev;
  logic signed [POS_W-1:0] cmd_acc_ff, nxt_cmd_acc;
  logic signed [POS_W-1:0] pos_min_ff, nxt_pos_min;
  logic signed [POS_W-1:0] pos_max_ff, nxt_pos_max;
  logic trial_prev_ff, nxt_trial_prev;
  logic alarm_ff, nxt_alarm;
  logic signed [TRQ_W-1:0] torque_ff, nxt_torque;
  logic [9:0] pceil_ff, nxt_pceil, nceil_ff, nxt_nceil;
  logic active, pos_mode;
  logic signed [TRQ_W+1:0] sum;
  logic signed [POS_W-1:0] margin, cmd_pos;
  logic [9:0] c_sel;

  // external select pin synchroniser
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else if (clk_en_i) begin
      sync1_ff <= torque_limit_select_input;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb begin
    active = servo_on_i && path_normal_i;
    pos_mode = (ctrl_mode_i == tcg_pkg::TCG_POSITION) || (ctrl_mode_i == tcg_pkg::TCG_FULL_CLOSED);
    nxt_bias = bias_ff;
    nxt_fric = fric_ff;
    nxt_cmd_prev = active ? cmd_active_i : 1'b0;
    // held until a command edge, then reloaded
    if (active && cmd_active_i && !cmd_prev_ff) begin
      nxt_bias = bias_torque_offset;
      if (pos_mode) begin
        nxt_fric = cmd_fwd_i ? fwd_friction_offset : rev_friction_offset;
      end else begin
        nxt_fric = tcg_pkg::TRQ_ZERO;
      end
    end
  end

  // ceiling selection
  always_comb begin
    c_sel = sync2_ff ? second_torque_ceiling : first_torque_ceiling;
    nxt_pceil = pceil_ff;
    nxt_nceil = nceil_ff;
    if (active) begin
      case (ceiling_select_mode)
        tcg_pkg::SEL_BOTH_FIRST: begin
          nxt_pceil = first_torque_ceiling;
          nxt_nceil = first_torque_ceiling;
        end
        tcg_pkg::SEL_BY_DIR: begin
          nxt_pceil = first_torque_ceiling;
          nxt_nceil = second_torque_ceiling;
        end
        tcg_pkg::SEL_BY_INPUT: begin
          nxt_pceil = c_sel;
          nxt_nceil = c_sel;
        end
        default: begin
          nxt_pceil = first_torque_ceiling;
          nxt_nceil = first_torque_ceiling;
        end
      endcase
    end
    // clamp keeps an out-of-range setting from widening the limit
    if (nxt_pceil > tcg_pkg::CEIL_MAX) nxt_pceil = tcg_pkg::CEIL_MAX;
    if (nxt_nceil > tcg_pkg::CEIL_MAX) nxt_nceil = tcg_pkg::CEIL_MAX;
  end

  // compensated torque and saturation
  always_comb begin
    // two guard bits so three summed terms never wrap
    sum = (TRQ_W+2)'(torque_cmd_i);
    if (ctrl_mode_i != tcg_pkg::TCG_TORQUE) sum = sum + (TRQ_W+2)'(bias_ff);
    if (active && pos_mode && cmd_active_i) sum = sum + (TRQ_W+2)'(fric_ff);
    if (sum > $signed({4'h0, pceil_ff})) nxt_torque = TRQ_W'($signed({2'h0, pceil_ff}));
    else if (sum < -$signed({4'h0, nceil_ff})) nxt_torque = -TRQ_W'($signed({2'h0, nceil_ff}));
    else nxt_torque = sum[TRQ_W-1:0];
  end

  // command range tracking and working range guard
  always_comb begin
    nxt_trial_prev = comm_trial_i;
    nxt_cmd_acc = cmd_acc_ff;
    nxt_pos_min = pos_min_ff;
    nxt_pos_max = pos_max_ff;
    cmd_pos = cmd_acc_ff + cmd_pos_delta_i;
    if (dev_clear_i || (comm_trial_i != trial_prev_ff)) begin
      nxt_cmd_acc = tcg_pkg::POS_ZERO;
      nxt_pos_min = tcg_pkg::POS_ZERO;
      nxt_pos_max = tcg_pkg::POS_ZERO;
    end else if (active) begin
      nxt_cmd_acc = cmd_pos;
      if (cmd_pos < pos_min_ff) nxt_pos_min = cmd_pos;
      if (cmd_pos > pos_max_ff) nxt_pos_max = cmd_pos;
    end
    margin = POS_W'((working_range_span > tcg_pkg::SPAN_MAX ? tcg_pkg::SPAN_MAX : working_range_span)
      * COUNTS_PER_TENTH);
    // a violation seen in the clear cycle wins over the clear
    nxt_alarm = alarm_ff;
    if (dev_clear_i) nxt_alarm = 1'b0;
    if (active && !panel_trial_i && !freq_analysis_i) begin
      if ((motor_pos_i > pos_max_ff + margin) || (motor_pos_i < pos_min_ff - margin)) begin
        nxt_alarm = 1'b1;
      end
    end
  end

  // compensation registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bias_ff <= tcg_pkg::TRQ_ZERO;
      fric_ff <= tcg_pkg::TRQ_ZERO;
      cmd_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      bias_ff <= nxt_bias;
      fric_ff <= nxt_fric;
      cmd_prev_ff <= nxt_cmd_prev;
    end
  end

  // ceiling registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pceil_ff <= '0;
      nceil_ff <= '0;
    end else if (clk_en_i) begin
      pceil_ff <= nxt_pceil;
      nceil_ff <= nxt_nceil;
    end
  end

  // torque output register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      torque_ff <= tcg_pkg::TRQ_ZERO;
    end else if (clk_en_i) begin
      torque_ff <= nxt_torque;
    end
  end

  // range and alarm registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_acc_ff <= tcg_pkg::POS_ZERO;
      pos_min_ff <= tcg_pkg::POS_ZERO;
      pos_max_ff <= tcg_pkg::POS_ZERO;
      trial_prev_ff <= 1'b0;
      alarm_ff <= 1'b0;
    end else if (clk_en_i) begin
      cmd_acc_ff <= nxt_cmd_acc;
      pos_min_ff <= nxt_pos_min;
      pos_max_ff <= nxt_pos_max;
      trial_prev_ff <= nxt_trial_prev;
      alarm_ff <= nxt_alarm;
    end
  end

  assign torque_out_o = torque_ff;
  assign pos_ceiling_o = pceil_ff;
  assign neg_ceiling_o = nceil_ff;
  assign range_alarm_o = alarm_ff;
endmodule

// ---- sim/tcg_torque_guard_assertions.sv ----
// concurrent checks on the torque guard ports
`timescale 1ns/1ns
module tcg_guard_chk #(
  parameter int TRQ_W = tcg_pkg::TRQ_W
) (
  // clock, reset and state
  input wire logic mclk_i, rst_n_i, clk_en_i, servo_on_i, path_normal_i,
  input wire logic dev_clear_i, panel_trial_i, freq_analysis_i, torque_limit_select_input,
  // settings
  input wire logic [9:0] first_torque_ceiling, second_torque_ceiling,
  input wire logic [1:0] ceiling_select_mode,
  // feedback
  input wire logic signed [tcg_pkg::POS_W-1:0] motor_pos_i,
  // outputs
  input wire logic signed [TRQ_W-1:0] torque_out_o,
  input wire logic [9:0] pos_ceiling_o, neg_ceiling_o,
  input wire logic range_alarm_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic run = clk_en_i && servo_on_i && path_normal_i;
  function automatic logic [9:0] cl(logic [9:0] v);
    return v > tcg_pkg::CEIL_MAX ? tcg_pkg::CEIL_MAX : v;
  endfunction
  a_sel_first: assert property (run && ceiling_select_mode == 2'h1 |=>
    pos_ceiling_o == cl($past(first_torque_ceiling)) && neg_ceiling_o == pos_ceiling_o) else $error("mode 1 ceiling");
  a_sel_split: assert property (run && ceiling_select_mode == 2'h2 |=>
    pos_ceiling_o == cl($past(first_torque_ceiling)) && neg_ceiling_o == cl($past(second_torque_ceiling)))
    else $error("mode 2 ceiling");
  a_sel_input: assert property ((run && ceiling_select_mode == 2'h3 && torque_limit_select_input) [*4] |=>
    pos_ceiling_o == cl($past(second_torque_ceiling)) && neg_ceiling_o == pos_ceiling_o) else $error("mode 3 ceiling");
  a_ceil_hold: assert property (!run |=> $stable(pos_ceiling_o) && $stable(neg_ceiling_o))
    else $error("ceiling moved while idle");
  a_alarm_clear: assert property (clk_en_i && dev_clear_i && motor_pos_i == '0 |=> !range_alarm_o)
    else $error("alarm not cleared");
  a_alarm_hold: assert property (range_alarm_o && !dev_clear_i |=> range_alarm_o) else $error("alarm dropped");
  a_alarm_gate: assert property ($rose(range_alarm_o) |->
    $past(run && !panel_trial_i && !freq_analysis_i)) else $error("alarm while guard off");
  a_torque_sat: assert property (torque_out_o <= $signed({2'h0, $past(pos_ceiling_o)})
    && -torque_out_o <= $signed({2'h0, $past(neg_ceiling_o)})) else $error("torque beyond ceiling");
  c_mode3: cover property (run && ceiling_select_mode == 2'h3 && torque_limit_select_input);
  c_alarm: cover property ($rose(range_alarm_o));
  c_neg_sat: cover property (torque_out_o < 0 && -torque_out_o == $signed({2'h0, neg_ceiling_o}));
endmodule
bind tcg_torque_guard tcg_guard_chk #(.TRQ_W(TRQ_W)) u_chk (.mclk_i, .rst_n_i, .clk_en_i, .servo_on_i, .path_normal_i,
  .dev_clear_i, .panel_trial_i, .freq_analysis_i, .torque_limit_select_input, .first_torque_ceiling,
  .second_torque_ceiling, .ceiling_select_mode, .motor_pos_i, .torque_out_o, .pos_ceiling_o, .neg_ceiling_o,
  .range_alarm_o);

// ---- sim/tcg_cmd_motor_model.sv ----
// host command source and motor position model
`timescale 1ns/1ns
module tcg_cmd_motor_model (
  input wire logic mclk_i, move_i, fwd_i, sel_i,
  input wire logic signed [31:0] wander_i,
  output logic cmd_active_o, cmd_fwd_o, limit_sel_o,
  output logic signed [31:0] delta_o, motor_pos_o
);
  initial {cmd_active_o, cmd_fwd_o, limit_sel_o, delta_o, motor_pos_o} = '0;
  always @(posedge mclk_i) begin
    cmd_active_o <= move_i;
    cmd_fwd_o <= fwd_i;
    delta_o <= move_i ? (fwd_i ? 32'sh3 : -32'sh3) : 32'sh0;
    limit_sel_o <= sel_i;
    motor_pos_o <= wander_i;
  end
endmodule

// ---- sim/tcg_torque_guard_tb.sv ----
// self-checking bench for the torque guard
`timescale 1ns/1ns
module tcg_torque_guard_tb;
  logic mclk = 0, rst_n = 0, son = 0, dclr = 0, ptr = 0, fa = 0, move = 0, fwd = 0, sel = 0, act = 0;
  logic ca, cf, ls, alarm;
  logic ce = 1, pn = 1, ct = 0;
  logic [1:0] cm = 0, sm = 1;
  logic signed [11:0] bias = 0, ff = 0, rf = 0, tc = 0, tq, bm = 0, fm = 0, sum;
  logic [9:0] c1 = 0, c2 = 0, pc, nc, ep, eng;
  logic signed [31:0] dl, mp, wd = 0;
  int seed = 70617, fail_count = 0, check_count = 0;
  always #5 mclk = ~mclk;
  tcg_cmd_motor_model pm (.mclk_i(mclk), .move_i(move), .fwd_i(fwd), .sel_i(sel), .wander_i(wd),
    .cmd_active_o(ca), .cmd_fwd_o(cf), .limit_sel_o(ls), .delta_o(dl), .motor_pos_o(mp));
  tcg_torque_guard dut (.mclk_i(mclk), .rst_n_i(rst_n), .clk_en_i(ce), .servo_on_i(son), .path_normal_i(pn),
    .ctrl_mode_i(cm), .dev_clear_i(dclr), .comm_trial_i(ct), .panel_trial_i(ptr), .freq_analysis_i(fa),
    .torque_limit_select_input(ls), .bias_torque_offset(bias), .fwd_friction_offset(ff), .rev_friction_offset(rf),
    .first_torque_ceiling(c1), .second_torque_ceiling(c2), .ceiling_select_mode(sm), .working_range_span(11'h001),
    .cmd_active_i(ca), .cmd_fwd_i(cf), .cmd_pos_delta_i(dl), .motor_pos_i(mp), .torque_cmd_i(tc),
    .torque_out_o(tq), .pos_ceiling_o(pc), .neg_ceiling_o(nc), .range_alarm_o(alarm));
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] cl(logic [9:0] v);
    return v > tcg_pkg::CEIL_MAX ? tcg_pkg::CEIL_MAX : v;
  endfunction
  task automatic verify;
    if (move && !act) begin
      bm = bias;
      fm = (cm == 2'h0 || cm == 2'h3) ? (fwd ? ff : rf) : 12'sh0;
    end
    act = move;
    sum = tc + (cm != 2'h2 ? bm : 12'sh0) + (move && (cm == 2'h0 || cm == 2'h3) ? fm : 12'sh0);
    ep = (sm == 2'h3 && sel) ? cl(c2) : cl(c1);
    eng = (sm == 2'h2 || (sm == 2'h3 && sel)) ? cl(c2) : cl(c1);
    if (sum > $signed({2'h0, ep}))
      sum = $signed({2'h0, ep});
    if (sum < -$signed({2'h0, eng}))
      sum = -$signed({2'h0, eng});
    check(pc, ep);
    check(nc, eng);
    check(tq, sum);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    tick(6);
    rst_n = 1;
    tick(2);
    son = 1;
    for (int i = 0; i < 80; i++) begin
      {cm, sm, sel, move, fwd} = 7'($random(seed));
      bias = 12'($random(seed) % 32'sh65);
      ff = 12'($random(seed) % 32'sh65);
      rf = 12'($random(seed) % 32'sh65);
      tc = 12'($random(seed) % 32'sh2BC);
      c1 = i == 0 ? 10'h1F5 : 10'($random(seed));
      c2 = i == 1 ? 10'h1F4 : 10'($random(seed));
      tick(6);
      verify();
    end
    // no ceiling change while servo is off
    son = 0;
    move = 0;
    c1 = ep ^ 10'h005;
    c2 = ep ^ 10'h005;
    tick(3);
    check(pc, ep);
    // a command already present at servo-on counts as its start
    move = 1;
    bias = -bias;
    tick(3);
    son = 1;
    act = 0;
    tick(6);
    verify();
    // blocked command path, then a held clock enable, both freeze the ceilings
    pn = 0;
    c1 = ep ^ 10'h005;
    c2 = ep ^ 10'h005;
    tick(3);
    check(pc, ep);
    pn = 1;
    ce = 0;
    tick(3);
    check(pc, ep);
    ce = 1;
    move = 0;
    dclr = 1;
    tick(3);
    dclr = 0;
    for (int k = 0; k < 4; k++) begin
      wd = k == 0 ? 32'shCCD : (k == 3 ? -32'shCCE : 32'shCCE);
      tick(1);
      {ptr, fa} = k == 1 ? 2'h2 : (k == 2 ? 2'h1 : 2'h0);
      tick(3);
      check(alarm, k == 3);
    end
    wd = 0;
    dclr = 1;
    tick(2);
    check(alarm, 1'b0);
    // widen the command range, then let a trial start clear it
    dclr = 0;
    {move, fwd} = 2'h3;
    tick(20);
    move = 0;
    wd = 32'shCCE;
    tick(4);
    check(alarm, 1'b0);
    ct = 1;
    tick(4);
    check(alarm, 1'b1);
    test_done();
  end
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule
